// File: rtl/synth_cfg_pkg.sv
// Shared constants for the synthesizer configuration and lock pin block
package synth_cfg_pkg;
   // ---------------------------------------------------------------
   // Register byte offsets on the bus
   // ---------------------------------------------------------------
   localparam logic [3:0] ref_cfg_addr = 4'h0;
   localparam logic [3:0] fb_cfg_addr = 4'h4;
   localparam logic [3:0] status_addr = 4'h8;

   // ---------------------------------------------------------------
   // Reference configuration word layout
   // ---------------------------------------------------------------
   localparam int ref_div_lsb = 0;
   localparam int ref_div_w = 12;
   localparam int lock_sel_lsb = 12;
   localparam int lock_sel_w = 4;
   localparam int shutdown_bit = 16;
   localparam int gate_bit = 17;
   localparam int tap_en_bit = 18;

   // ---------------------------------------------------------------
   // Feedback configuration word layout
   // ---------------------------------------------------------------
   localparam int fb_div_lsb = 0;
   localparam int fb_div_w = 18;
   localparam int post_div_lsb = 18;
   localparam int post_div_w = 4;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [11:0] ref_div_rst = 12'h00A;
   localparam logic [17:0] fb_div_rst = 18'h002F8;
   localparam logic [3:0] post_div_rst = 4'h2;
   localparam logic [3:0] lock_sel_rst = 4'h0;
   localparam logic shutdown_rst = 1'b0;
   localparam logic gate_rst = 1'b1;
   localparam logic tap_en_rst = 1'b0;

   // Post divider legal range
   localparam logic [3:0] post_div_min = 4'h2;
   localparam logic [3:0] post_div_max = 4'h8;

   // ---------------------------------------------------------------
   // Lock pin selector codes
   // ---------------------------------------------------------------
   localparam logic [3:0] sel_hiz = 4'h0;
   localparam logic [3:0] sel_high = 4'h1;
   localparam logic [3:0] sel_low = 4'h2;
   localparam logic [3:0] sel_dld_hi = 4'h3;
   localparam logic [3:0] sel_dld_lo = 4'h4;
   localparam logic [3:0] sel_ald_pp = 4'h5;
   localparam logic [3:0] sel_ald_nmos = 4'h6;
   localparam logic [3:0] sel_ald_pmos = 4'h7;
   localparam logic [3:0] sel_fb_half = 4'h9;
   localparam logic [3:0] sel_ref_half = 4'hB;

   // Calibration busy time
   localparam int cal_time_us = 10;
   localparam int clk_mhz = 50;
   localparam int cal_cycles = cal_time_us * clk_mhz;
endpackage

// File: rtl/sync3.sv
// Three-stage input synchroniser, change counted when stages two and three agree
`timescale 1ns/1ps
module sync3 (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic rst_val_i,
   input wire logic d_i,
   output logic q_o
);
   logic s1;
   logic s2;
   logic s3;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1 <= rst_val_i;
         s2 <= rst_val_i;
         s3 <= rst_val_i;
      end else if (ce_i) begin
         s1 <= d_i;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // Filtered level follows only once two late stages agree
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_o <= rst_val_i;
      end else if (ce_i && (s2 == s3)) begin
         q_o <= s3;
      end
   end
endmodule

// File: rtl/div_half.sv
// Programmable divider whose terminal pulse toggles a 50% duty output
`timescale 1ns/1ps
module div_half #(
   parameter int W = 12
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic run_i,
   input wire logic [W-1:0] div_i,
   output logic tick_o,
   output logic half_o
);
   logic [W-1:0] count;

   // Zero divide is invalid; it is treated as one to keep the counter sane
   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         count <= '0;
      end else if (ce_i) begin
         if (count + W'(1) >= div_i) begin
            count <= '0;
         end else begin
            count <= count + W'(1);
         end
      end
   end

   assign tick_o = ce_i && run_i && (count + W'(1) >= div_i);

   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         half_o <= 1'b0;
      end else if (tick_o) begin
         half_o <= ~half_o;
      end
   end
endmodule

// File: rtl/synth_cfg.sv
// Synthesizer divider configuration, lock pin selector and output gating
// How it works
// - Reference divider is 12 bits, 1 to 4095, resets to 10; zero invalid.
// - Lock selector 0 floats pin, 1 drives high, 2 drives low.
// - Selector 3 gives digital lock high-true, 4 low-true, both push-pull.
// - Selectors 5, 6, 7 give analog lock: push-pull, NMOS drain, PMOS drain.
// - Selector 9 gives feedback divider halved, 11 reference halved; others invalid.
// - Shutdown bit set powers down everything regardless of other controls.
// - Global gate bit clear disables the main outputs; the oscillator tap follows only its own bit and the shutdown bit.
// - Oscillator tap output enabled only while its bit is one.
// - Each feedback word write outside shutdown starts the frequency calibration.
// - Feedback divider is 18-bit binary, 1 to 262143, resets to 760.
// - Feedback divider follows post divider; total is their product.
// - Locked frequency is reference times feedback times post over reference div.
// - Post divider accepts 2 to 8, resets to 2; other codes invalid.
// - Post divider always stays in output and feedback path, no bypass.
// - Gate pin low disables the main outputs like the global gate bit; the tap is not gated.
//
// The Wishbone interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
module synth_cfg (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Classic Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Oscillator side
   input wire logic osc_clk_i,
   input wire logic dig_lock_i,
   input wire logic ana_lock_i,
   input wire logic output_gate_pin_i,
   // Lock indicator pin as output, enable
   output logic lock_indicator_pin_o,
   output logic lock_indicator_pin_oe_o,
   output logic osc_tap_o,
   output logic outputs_enabled_o,
   output logic powered_o,
   output logic cal_busy_o,
   output logic cal_start_o,
   output logic [31:0] total_fb_div_o
);
   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   logic [11:0] ref_divide;
   logic [3:0] lock_sel;
   logic full_shutdown;
   logic all_outputs_gate;
   logic tap_enable;
   logic [17:0] fb_divide;
   logic [3:0] post_osc_divide_value;
   logic gate_pin_sync;
   logic dig_lock_sync;
   logic ana_lock_sync;
   logic osc_sync;
   logic wr_req;
   logic rd_req;
   logic wr_ref;
   logic wr_fb;
   logic [31:0] next_rdata;
   logic [8:0] cal_count;
   logic fb_tick;
   logic fb_half;
   logic ref_tick;
   logic ref_half;
   logic running;
   logic post_tick;
   logic [3:0] post_count;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   sync3 u_gate_sync (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .rst_val_i(1'b1),
      .d_i(output_gate_pin_i), .q_o(gate_pin_sync)
   );
   sync3 u_dld_sync (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .rst_val_i(1'b1),
      .d_i(dig_lock_i), .q_o(dig_lock_sync)
   );
   sync3 u_ald_sync (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .rst_val_i(1'b1),
      .d_i(ana_lock_i), .q_o(ana_lock_sync)
   );
   sync3 u_osc_sync (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .rst_val_i(1'b1),
      .d_i(osc_clk_i), .q_o(osc_sync)
   );

   // ---------------------------------------------------------------
   // Wishbone decode
   // ---------------------------------------------------------------
   assign wr_req = cyc_i && stb_i && we_i && !ack_o && ce_i;
   assign rd_req = cyc_i && stb_i && !we_i && !ack_o && ce_i;
   assign wr_ref = wr_req && (adr_i == synth_cfg_pkg::ref_cfg_addr) && (&sel_i);
   assign wr_fb = wr_req && (adr_i == synth_cfg_pkg::fb_cfg_addr) && (&sel_i);

   // One answer after one wait state; unmapped reads return zero, partial writes ignored
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else if (ce_i) begin
         ack_o <= cyc_i && stb_i && !ack_o;
      end
   end

   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (adr_i)
         synth_cfg_pkg::ref_cfg_addr: begin
            next_rdata[synth_cfg_pkg::ref_div_lsb +: synth_cfg_pkg::ref_div_w] = ref_divide;
            next_rdata[synth_cfg_pkg::lock_sel_lsb +: synth_cfg_pkg::lock_sel_w] = lock_sel;
            next_rdata[synth_cfg_pkg::shutdown_bit] = full_shutdown;
            next_rdata[synth_cfg_pkg::gate_bit] = all_outputs_gate;
            next_rdata[synth_cfg_pkg::tap_en_bit] = tap_enable;
         end
         synth_cfg_pkg::fb_cfg_addr: begin
            next_rdata[synth_cfg_pkg::fb_div_lsb +: synth_cfg_pkg::fb_div_w] = fb_divide;
            next_rdata[synth_cfg_pkg::post_div_lsb +: synth_cfg_pkg::post_div_w] =
               post_osc_divide_value;
         end
         synth_cfg_pkg::status_addr: begin
            next_rdata[0] = cal_busy_o;
            next_rdata[1] = dig_lock_sync;
            next_rdata[2] = ana_lock_sync;
            next_rdata[3] = outputs_enabled_o;
         end
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (rd_req) begin
         dat_o <= next_rdata;
      end
   end

   // ---------------------------------------------------------------
   // Reference configuration word
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ref_divide <= synth_cfg_pkg::ref_div_rst;
         lock_sel <= synth_cfg_pkg::lock_sel_rst;
         full_shutdown <= synth_cfg_pkg::shutdown_rst;
         all_outputs_gate <= synth_cfg_pkg::gate_rst;
         tap_enable <= synth_cfg_pkg::tap_en_rst;
      end else if (wr_ref) begin
         ref_divide <= dat_i[synth_cfg_pkg::ref_div_lsb +: synth_cfg_pkg::ref_div_w];
         lock_sel <= dat_i[synth_cfg_pkg::lock_sel_lsb +: synth_cfg_pkg::lock_sel_w];
         full_shutdown <= dat_i[synth_cfg_pkg::shutdown_bit];
         all_outputs_gate <= dat_i[synth_cfg_pkg::gate_bit];
         tap_enable <= dat_i[synth_cfg_pkg::tap_en_bit];
      end
   end

   // ---------------------------------------------------------------
   // Feedback configuration word and calibration
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fb_divide <= synth_cfg_pkg::fb_div_rst;
         post_osc_divide_value <= synth_cfg_pkg::post_div_rst;
      end else if (wr_fb) begin
         fb_divide <= dat_i[synth_cfg_pkg::fb_div_lsb +: synth_cfg_pkg::fb_div_w];
         post_osc_divide_value <=
            dat_i[synth_cfg_pkg::post_div_lsb +: synth_cfg_pkg::post_div_w];
      end
   end

   // Restart on every feedback word write outside shutdown, even mid-calibration; host relies on it after ref change
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cal_count <= '0;
      end else if (ce_i) begin
         if (wr_fb && !full_shutdown) begin
            cal_count <= 9'(synth_cfg_pkg::cal_cycles);
         end else if (cal_count != '0) begin
            cal_count <= cal_count - 9'h001;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cal_start_o <= 1'b0;
      end else if (ce_i) begin
         cal_start_o <= wr_fb && !full_shutdown;
      end
   end

   assign cal_busy_o = cal_count != '0;

   // Total feedback division: product of both dividers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         total_fb_div_o <= 32'h0000_0000;
      end else if (ce_i) begin
         total_fb_div_o <= {14'h0000, fb_divide} * {28'h0000000, post_osc_divide_value};
      end
   end

   // ---------------------------------------------------------------
   // Divider chain: post divider feeds feedback divider, no bypass
   // ---------------------------------------------------------------
   assign running = !full_shutdown;
   logic osc_d;
   logic osc_rise;

   always_ff @(posedge clk_i) begin
      // Matches the synchroniser reset level, so no false edge follows reset
      if (rst_i) begin
         osc_d <= 1'b1;
      end else if (ce_i) begin
         osc_d <= osc_sync;
      end
   end

   assign osc_rise = osc_sync && !osc_d;

   // Post divider counts oscillator edges; always in path
   always_ff @(posedge clk_i) begin
      if (rst_i || !running) begin
         post_count <= '0;
      end else if (ce_i && osc_rise) begin
         if (post_count + 4'h1 >= post_osc_divide_value) begin
            post_count <= '0;
         end else begin
            post_count <= post_count + 4'h1;
         end
      end
   end

   assign post_tick = osc_rise && (post_count + 4'h1 >= post_osc_divide_value);

   div_half #(.W(18)) u_fb_div (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i && post_tick), .run_i(running),
      .div_i(fb_divide), .tick_o(fb_tick), .half_o(fb_half)
   );

   div_half #(.W(12)) u_ref_div (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .run_i(running),
      .div_i(ref_divide), .tick_o(ref_tick), .half_o(ref_half)
   );

   // ---------------------------------------------------------------
   // Output gating and tap
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         outputs_enabled_o <= 1'b0;
         osc_tap_o <= 1'b0;
         powered_o <= 1'b0;
      end else if (ce_i) begin
         outputs_enabled_o <= running && all_outputs_gate && gate_pin_sync;
         osc_tap_o <= running && tap_enable && osc_sync;
         powered_o <= running;
      end
   end

   // ---------------------------------------------------------------
   // Lock indicator pin
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lock_indicator_pin_o <= 1'b0;
         lock_indicator_pin_oe_o <= 1'b0;
      end else if (ce_i) begin
         lock_indicator_pin_o <= 1'b0;
         lock_indicator_pin_oe_o <= 1'b0;
         if (running) begin
            unique case (lock_sel)
               synth_cfg_pkg::sel_hiz: begin
                  lock_indicator_pin_oe_o <= 1'b0;
               end
               synth_cfg_pkg::sel_high: begin
                  lock_indicator_pin_o <= 1'b1;
                  lock_indicator_pin_oe_o <= 1'b1;
               end
               synth_cfg_pkg::sel_low: begin
                  lock_indicator_pin_oe_o <= 1'b1;
               end
               synth_cfg_pkg::sel_dld_hi: begin
                  lock_indicator_pin_o <= dig_lock_sync;
                  lock_indicator_pin_oe_o <= 1'b1;
               end
               synth_cfg_pkg::sel_dld_lo: begin
                  lock_indicator_pin_o <= !dig_lock_sync;
                  lock_indicator_pin_oe_o <= 1'b1;
               end
               synth_cfg_pkg::sel_ald_pp: begin
                  lock_indicator_pin_o <= ana_lock_sync;
                  lock_indicator_pin_oe_o <= 1'b1;
               end
               synth_cfg_pkg::sel_ald_nmos: begin
                  lock_indicator_pin_oe_o <= !ana_lock_sync;
               end
               synth_cfg_pkg::sel_ald_pmos: begin
                  lock_indicator_pin_o <= 1'b1;
                  lock_indicator_pin_oe_o <= ana_lock_sync;
               end
               synth_cfg_pkg::sel_fb_half: begin
                  lock_indicator_pin_o <= fb_half;
                  lock_indicator_pin_oe_o <= 1'b1;
               end
               synth_cfg_pkg::sel_ref_half: begin
                  lock_indicator_pin_o <= ref_half;
                  lock_indicator_pin_oe_o <= 1'b1;
               end
               // Invalid codes float the pin
               default: lock_indicator_pin_oe_o <= 1'b0;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   cal_restart_a: assert property (wr_fb && !full_shutdown |=> cal_busy_o && cal_start_o)
      else $error("calibration not started by feedback write");
   cal_length_a: assert property (cal_start_o |-> cal_count == 9'(synth_cfg_pkg::cal_cycles))
      else $error("calibration length wrong");
   gate_off_a: assert property (ce_i && !all_outputs_gate |=> !outputs_enabled_o)
      else $error("outputs on with gate bit clear");
   pin_gate_a: assert property (ce_i && !gate_pin_sync |=> !outputs_enabled_o)
      else $error("outputs on with gate pin low");
   shutdown_all_a: assert property (ce_i && full_shutdown |=> !powered_o && !osc_tap_o && !lock_indicator_pin_oe_o)
      else $error("activity during shutdown");
   tap_off_a: assert property (ce_i && !tap_enable |=> !osc_tap_o)
      else $error("tap on while disabled");
   lock_float_a: assert property (ce_i && lock_sel == synth_cfg_pkg::sel_hiz |=> !lock_indicator_pin_oe_o)
      else $error("lock pin driven in float mode");
   dld_low_a: assert property (ce_i && running && lock_sel == synth_cfg_pkg::sel_dld_lo |=> lock_indicator_pin_oe_o && lock_indicator_pin_o == !$past(dig_lock_sync))
      else $error("inverted digital lock wrong");
   ald_nmos_a: assert property (ce_i && running && lock_sel == synth_cfg_pkg::sel_ald_nmos |=> !lock_indicator_pin_o && lock_indicator_pin_oe_o == !$past(ana_lock_sync))
      else $error("open-drain lock output wrong");
   // Count left above a newly lowered divide value wraps on the next oscillator rise; not checked here
   post_range_a: assert property (post_tick && post_count < post_osc_divide_value |->
      post_count == post_osc_divide_value - 4'h1)
      else $error("post divider terminal count wrong");

   cal_cov: cover property (wr_fb ##1 cal_busy_o);
   gate_cov: cover property (outputs_enabled_o ##1 !outputs_enabled_o);
   fbhalf_cov: cover property (lock_sel == synth_cfg_pkg::sel_fb_half && fb_tick);
   refhalf_cov: cover property (lock_sel == synth_cfg_pkg::sel_ref_half && ref_tick);
endmodule

// File: tb/osc_model.sv
// Free-running oscillator stand-in feeding the block's oscillator sample input
`timescale 1ns/1ps
module osc_model #(
   parameter int HALF = 3
) (
   input wire logic clk_i,
   output logic osc_clk_o
);
   int cnt = 0;
   // Runs at all times: the real oscillator has no idle gaps
   initial osc_clk_o = 1'b0;
   always @(posedge clk_i) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) begin
         osc_clk_o <= ~osc_clk_o;
      end
   end
endmodule

// File: tb/synth_cfg_tb.sv
// Self-checking bench for the synthesizer configuration block
`timescale 1ns/1ps
module synth_cfg_tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [3:0] adr_i = 4'h0;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic dig_lock_i = 1'b0;
   logic ana_lock_i = 1'b0;
   logic gate_pin = 1'b1;
   logic osc_clk;
   logic [31:0] dat_o, total_fb_div_o, rd;
   logic ack_o, pin_o, pin_oe_o, osc_tap_o, outs_en, powered_o, cal_busy_o, cal_start_o;
   int fails = 0;
   int num_checks = 0;
   int starts = 0;
   always #10 clk_i = ~clk_i;
   always @(posedge clk_i) if (cal_start_o === 1'b1) starts++;
   osc_model #(.HALF(3)) osc (.clk_i(clk_i), .osc_clk_o(osc_clk));
   synth_cfg DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .osc_clk_i(osc_clk), .dig_lock_i(dig_lock_i), .ana_lock_i(ana_lock_i),
      .output_gate_pin_i(gate_pin), .lock_indicator_pin_o(pin_o),
      .lock_indicator_pin_oe_o(pin_oe_o), .osc_tap_o(osc_tap_o), .outputs_enabled_o(outs_en),
      .powered_o(powered_o), .cal_busy_o(cal_busy_o), .cal_start_o(cal_start_o),
      .total_fb_div_o(total_fb_div_o));
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      num_checks++;
      if (seen !== want) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic wrap_up();
      if (fails == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Classic cycle; returns one idle edge after the ack edge
   task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
      input logic [31:0] d);
      int k;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= s;
      dat_i <= d;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack_o !== 1'b1 && k < 20);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (k >= 20) begin
         fails++;
         wrap_up();
      end
      @(posedge clk_i);
   endtask
   task automatic watch(ref logic s, input int cyc, output int hi, output int tg);
      logic p;
      hi = 0;
      tg = 0;
      p = s;
      repeat (cyc) begin
         @(posedge clk_i);
         hi += (s === 1'b1);
         tg += (s !== p);
         p = s;
      end
   endtask
   function automatic logic [1:0] exp_pin(input logic [3:0] c, input logic d, input logic a);
      case (c)
         4'h1: exp_pin = 2'b11;
         4'h2: exp_pin = 2'b10;
         4'h3: exp_pin = {1'b1, d};
         4'h4: exp_pin = {1'b1, ~d};
         4'h5: exp_pin = {1'b1, a};
         4'h6: exp_pin = {~a, 1'b0};
         4'h7: exp_pin = {a, 1'b1};
         default: exp_pin = 2'b00;
      endcase
   endfunction
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      logic [1:0] e;
      int hi, tg, t;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      wb(1'b0, 4'h0, 4'hF, 32'h0);
      check(rd, 32'h0002000A);
      wb(1'b0, 4'h4, 4'hF, 32'h0);
      check(rd, 32'h000802F8);
      check(total_fb_div_o, 32'h000005F0);
      check({powered_o, outs_en, pin_oe_o}, 32'h6);
      wb(1'b0, 4'hC, 4'hF, 32'h0);
      check(rd, 32'h0);
      wb(1'b1, 4'h0, 4'h3, 32'h00000005);
      wb(1'b1, 4'h0, 4'hF, 32'h00020FFF);
      wb(1'b0, 4'h0, 4'hF, 32'h0);
      check(rd, 32'h00020FFF);
      // Host restarts calibration after the reference change
      wb(1'b1, 4'h4, 4'hF, 32'h0023FFFF);
      check(total_fb_div_o, 32'h001FFFF8);
      wb(1'b0, 4'h8, 4'hF, 32'h0);
      check(rd[0], 32'h1);
      repeat (100) @(posedge clk_i);
      wb(1'b1, 4'h4, 4'hF, 32'h0023FFFF);
      t = 0;
      while (cal_busy_o === 1'b1 && t < 600) begin
         @(posedge clk_i);
         t++;
      end
      check(t >= 495 && t <= 500, 32'h1);
      for (int p = 2; p <= 8; p++) begin
         wb(1'b1, 4'h4, 4'hF, (p << 18) | 32'h3);
         check(total_fb_div_o, 3 * p);
      end
      check(starts, 32'd9);
      wb(1'b1, 4'h4, 4'hF, 32'h00080001);
      wb(1'b1, 4'h0, 4'hF, 32'h0002900A);
      watch(pin_o, 240, hi, tg);
      check(tg >= 19 && tg <= 21, 32'h1);
      for (int m = 0; m < 2; m++) begin
         dig_lock_i <= (m == 0);
         ana_lock_i <= (m == 1);
         repeat (8) @(posedge clk_i);
         for (int c = 0; c < 16; c++) begin
            wb(1'b1, 4'h0, 4'hF, 32'h0002000A | (c << 12));
            repeat (3) @(posedge clk_i);
            e = exp_pin(c, m == 0, m == 1);
            if (c == 9 || c == 11) check(pin_oe_o, 32'h1);
            else if (e[1]) check({pin_oe_o, pin_o}, e);
            else check(pin_oe_o, 32'h0);
         end
      end
      wb(1'b1, 4'h0, 4'hF, 32'h0002B00A);
      watch(pin_o, 200, hi, tg);
      check(tg >= 19 && tg <= 21, 32'h1);
      wb(1'b1, 4'h0, 4'hF, 32'h0000000A);
      repeat (3) @(posedge clk_i);
      check(outs_en, 32'h0);
      wb(1'b1, 4'h0, 4'hF, 32'h0002000A);
      gate_pin <= 1'b0;
      repeat (8) @(posedge clk_i);
      check(outs_en, 32'h0);
      gate_pin <= 1'b1;
      repeat (8) @(posedge clk_i);
      check(outs_en, 32'h1);
      wb(1'b1, 4'h0, 4'hF, 32'h0006000A);
      watch(osc_tap_o, 60, hi, tg);
      check(hi > 5 && hi < 55, 32'h1);
      wb(1'b1, 4'h0, 4'hF, 32'h0002000A);
      watch(osc_tap_o, 60, hi, tg);
      check(hi, 32'h0);
      wb(1'b1, 4'h0, 4'hF, 32'h0007100A);
      wb(1'b1, 4'h4, 4'hF, 32'h000802F8);
      repeat (3) @(posedge clk_i);
      check({powered_o, outs_en, pin_oe_o, cal_busy_o}, 32'h0);
      watch(osc_tap_o, 60, hi, tg);
      check(hi, 32'h0);
      wrap_up();
   end
endmodule
